// *** src/control_bit_source_select.sv ***
// control-bit source selection with its register port
//
// The plain strobed port was chosen for this implementation.
`timescale 1ns/1ps
`include "cbs_consts.svh"

module control_bit_source_select
    import cbs_pkg::*;
#(
    parameter int SAMPLE_W = 12
)(
    // clock and reset
    input  wire logic                   sys_clk,
    input  wire logic                   srst,
    // register port
    input  wire logic [`CBS_ADDR_W-1:0] reg_addr,
    input  wire logic [`CBS_DATA_W-1:0] reg_wdata,
    input  wire logic                   reg_wr,
    input  wire logic                   reg_rd,
    output logic      [`CBS_DATA_W-1:0] reg_rdata,
    // configured control bits per sample
    input  wire logic [1:0]             cs_count,
    // sample path
    input  wire sample_in_t             samp_in,
    output sample_out_t                 samp_out,
    // pattern word for the test generator
    output logic      [15:0]            user_pattern_four
);

    // refuse sample widths the data mask cannot serve
    if (SAMPLE_W < 1 || SAMPLE_W > 16) begin : g_bad_sample_w
        $error("SAMPLE_W must be 1 to 16");
    end

    // reset image of the selector register, named so fields can be sliced
    localparam logic [`CBS_DATA_W-1:0] RST_CFG = `CBS_RST_SRC_CFG;

    // register state
    logic [`CBS_DATA_W-1:0] pat_lo_q;
    logic [`CBS_DATA_W-1:0] pat_hi_q;
    logic [2:0]             sel_upper_q;
    logic [2:0]             sel_lower_q;
    logic [`CBS_DATA_W-1:0] rdata_q;
    sample_out_t            out_q;

    // address decode
    wire logic hit_lo;
    wire logic hit_hi;
    wire logic hit_cfg;
    wire logic [`CBS_DATA_W-1:0] cfg_view;
    wire logic [`CBS_DATA_W-1:0] rdata_d;

    assign hit_lo  = (reg_addr == `CBS_OFF_PAT4_LO);
    assign hit_hi  = (reg_addr == `CBS_OFF_PAT4_HI);
    assign hit_cfg = (reg_addr == `CBS_OFF_SRC_CFG);

    // bits 7 and 3 read as zero
    assign cfg_view = {1'b0, sel_upper_q, 1'b0, sel_lower_q};

    assign rdata_d = hit_lo  ? pat_lo_q :
                     hit_hi  ? pat_hi_q :
                     hit_cfg ? cfg_view :
                     `CBS_RD_UNMAPPED;

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            pat_lo_q    <= `CBS_RST_PAT4_LO;
            pat_hi_q    <= `CBS_RST_PAT4_HI;
            sel_upper_q <= RST_CFG[`CBS_SEL_UPPER_LSB +: `CBS_SEL_W];
            sel_lower_q <= RST_CFG[`CBS_SEL_LOWER_LSB +: `CBS_SEL_W];
        end else if (reg_wr) begin
            if (hit_lo) begin
                pat_lo_q <= reg_wdata;
            end
            if (hit_hi) begin
                pat_hi_q <= reg_wdata;
            end
            if (hit_cfg) begin
                sel_upper_q <= reg_wdata[`CBS_SEL_UPPER_LSB +: `CBS_SEL_W];
                sel_lower_q <= reg_wdata[`CBS_SEL_LOWER_LSB +: `CBS_SEL_W];
            end
        end
    end

    // read data valid only in the cycle after the strobe
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rdata_q <= `CBS_RD_UNMAPPED;
        end else if (reg_rd) begin
            rdata_q <= rdata_d;
        end else begin
            rdata_q <= `CBS_RD_UNMAPPED;
        end
    end

    // enables from the control-bit count
    wire logic en_upper;
    wire logic en_lower;
    wire logic bit_upper;
    wire logic bit_lower;

    assign en_upper = (cs_count >= `CBS_CS_UPPER_MIN);
    assign en_lower = (cs_count == `CBS_CS_LOWER_EQ);

    ctrl_bit_mux u_mux_upper (
        .sel     (sel_upper_q),
        .enable  (en_upper),
        .srcs    (samp_in.src),
        .bit_out (bit_upper)
    );

    ctrl_bit_mux u_mux_lower (
        .sel     (sel_lower_q),
        .enable  (en_lower),
        .srcs    (samp_in.src),
        .bit_out (bit_lower)
    );

    // sample data masked to its width
    wire logic [15:0] data_masked;
    assign data_masked = samp_in.data & 16'((32'h0001_0000 >> (16 - SAMPLE_W)) - 32'h1);

    always_ff @(posedge sys_clk) begin
        if (srst) begin
            out_q <= '0;
        end else begin
            out_q.valid <= samp_in.valid;
            out_q.data  <= data_masked;
            out_q.ctrl  <= {bit_upper, bit_lower};
        end
    end

    assign reg_rdata         = rdata_q;
    assign samp_out          = out_q;
    assign user_pattern_four = {pat_hi_q, pat_lo_q};

    // checks

    property p_upper_follows_code;
        @(posedge sys_clk) disable iff (srst)
        (en_upper && sel_upper_q == SRC_THRESHOLD)
            |=> (samp_out.ctrl[1] == $past(samp_in.src.threshold_flag));
    endproperty
    a_upper_follows_code: assert property (p_upper_follows_code)
        else $error("upper control bit does not follow the flag");

    property p_upper_overrange;
        @(posedge sys_clk) disable iff (srst)
        (en_upper && sel_upper_q == SRC_OVERRANGE)
            |=> (samp_out.ctrl[1] == $past(samp_in.src.overrange));
    endproperty
    a_upper_overrange: assert property (p_upper_overrange)
        else $error("upper control bit does not follow overrange");

    property p_upper_gated;
        @(posedge sys_clk) disable iff (srst)
        (cs_count < 2'h2) |=> (samp_out.ctrl[1] == 1'b0);
    endproperty
    a_upper_gated: assert property (p_upper_gated)
        else $error("upper control bit set with too few control bits");

    property p_lower_sysref;
        @(posedge sys_clk) disable iff (srst)
        (cs_count == 2'h3 && sel_lower_q == SRC_SYSREF)
            |=> (samp_out.ctrl[0] == $past(samp_in.src.sysref));
    endproperty
    a_lower_sysref: assert property (p_lower_sysref)
        else $error("lowest control bit does not follow sysref");

    property p_lower_monitor;
        @(posedge sys_clk) disable iff (srst)
        (cs_count == 2'h3 && sel_lower_q == SRC_MONITOR)
            |=> (samp_out.ctrl[0] == $past(samp_in.src.monitor));
    endproperty
    a_lower_monitor: assert property (p_lower_monitor)
        else $error("lowest control bit does not follow monitor");

    property p_lower_gated;
        @(posedge sys_clk) disable iff (srst)
        (cs_count != 2'h3) |=> (samp_out.ctrl[0] == 1'b0);
    endproperty
    a_lower_gated: assert property (p_lower_gated)
        else $error("lowest control bit set with fewer than three control bits");

    property p_reset_zero;
        @(posedge sys_clk)
        srst |=> (sel_upper_q == 3'h0 && sel_lower_q == 3'h0 && samp_out.ctrl == 2'h0);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("selectors or control bits not zero after reset");

    property p_bad_code_zero;
        @(posedge sys_clk) disable iff (srst)
        (sel_upper_q == 3'h4 || sel_upper_q == 3'h6 || sel_upper_q == 3'h7)
            |=> (samp_out.ctrl[1] == 1'b0);
    endproperty
    a_bad_code_zero: assert property (p_bad_code_zero)
        else $error("unlisted code gave a nonzero control bit");

    property p_cfg_readback;
        @(posedge sys_clk) disable iff (srst)
        (reg_rd && hit_cfg)
            |=> (reg_rdata == {1'b0, $past(sel_upper_q), 1'b0, $past(sel_lower_q)});
    endproperty
    a_cfg_readback: assert property (p_cfg_readback)
        else $error("configuration readback wrong");

    property p_rdata_idle;
        @(posedge sys_clk) disable iff (srst)
        (!reg_rd) |=> (reg_rdata == 8'h00);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data not zero outside a read answer");

endmodule : control_bit_source_select

// *** src/cbs_consts.svh ***
// register offsets, field positions and reset values for the control-bit source block
`ifndef CBS_CONSTS_SVH
`define CBS_CONSTS_SVH

`define CBS_ADDR_W        12
`define CBS_DATA_W        8
`define CBS_OFF_PAT4_LO   12'h0557
`define CBS_OFF_PAT4_HI   12'h0558
`define CBS_OFF_SRC_CFG   12'h0559
`define CBS_RST_PAT4_LO   8'h00
`define CBS_RST_PAT4_HI   8'h00
`define CBS_RST_SRC_CFG   8'h00
`define CBS_SEL_UPPER_LSB 4
`define CBS_SEL_LOWER_LSB 0
`define CBS_SEL_W         3
`define CBS_CS_UPPER_MIN  2'h2
`define CBS_CS_LOWER_EQ   2'h3
`define CBS_RD_UNMAPPED   8'h00

`endif

// *** src/cbs_pkg.sv ***
// types shared by the control-bit source block
package cbs_pkg;

    typedef enum logic [2:0] {
        SRC_ZERO      = 3'h0,
        SRC_OVERRANGE = 3'h1,
        SRC_MONITOR   = 3'h2,
        SRC_THRESHOLD = 3'h3,
        SRC_SYSREF    = 3'h5
    } src_sel_t;

    typedef struct packed {
        logic overrange;
        logic monitor;
        logic threshold_flag;
        logic sysref;
    } ctrl_sources_t;

    typedef struct packed {
        logic       valid;
        logic [15:0] data;
        ctrl_sources_t src;
    } sample_in_t;

    typedef struct packed {
        logic       valid;
        logic [15:0] data;
        logic [1:0] ctrl;
    } sample_out_t;

endpackage : cbs_pkg

// *** src/ctrl_bit_mux.sv ***
// picks one control bit source from a 3-bit selector code
`timescale 1ns/1ps
module ctrl_bit_mux
    import cbs_pkg::*;
(
    // selection
    input  wire logic [2:0]    sel,
    input  wire logic          enable,
    // candidate sources
    input  wire ctrl_sources_t srcs,
    // chosen bit
    output wire logic          bit_out
);

    wire logic picked;

    // unlisted codes fall through to zero
    assign picked = (sel == SRC_OVERRANGE) ? srcs.overrange      :
                    (sel == SRC_MONITOR)   ? srcs.monitor        :
                    (sel == SRC_THRESHOLD) ? srcs.threshold_flag :
                    (sel == SRC_SYSREF)    ? srcs.sysref         :
                    1'b0;

    assign bit_out = enable & picked;

endmodule : ctrl_bit_mux

// *** tb/link_rx_model.sv ***
// far-side link receiver model: counts the valid samples it accepts
`timescale 1ns/1ps
module link_rx_model
    import cbs_pkg::*;
(
    // clock and reset
    input  wire logic        sys_clk,
    input  wire logic        srst,
    // sample stream from the block
    input  wire sample_out_t samp_out,
    // accepted sample count
    output logic [15:0]      rx_count_q
);
    always_ff @(posedge sys_clk) begin
        if (srst) begin
            rx_count_q <= 16'h0000;
        end else if (samp_out.valid === 1'b1) begin
            rx_count_q <= rx_count_q + 16'h0001;
        end
    end
endmodule : link_rx_model

// *** tb/control_bit_source_select_tb_top.sv ***
// testbench for the control-bit source block
`timescale 1ns/1ps
`include "cbs_consts.svh"
module control_bit_source_select_tb_top
    import cbs_pkg::*;
;
    typedef struct packed {
        logic [1:0] cs;
        logic [2:0] up;
        logic [2:0] lo;
        logic [3:0] src;
        logic [1:0] exp;
    } row_t;
    localparam int NROWS = 13;
    row_t        rows [NROWS] = '{
        '{2'h3, 3'h1, 3'h5, 4'h8, 2'h2}, '{2'h3, 3'h1, 3'h5, 4'h9, 2'h3}, '{2'h3, 3'h2, 3'h3, 4'h4, 2'h2},
        '{2'h3, 3'h2, 3'h3, 4'h2, 2'h1}, '{2'h3, 3'h3, 3'h2, 4'h2, 2'h2}, '{2'h3, 3'h5, 3'h1, 4'h1, 2'h2},
        '{2'h3, 3'h5, 3'h1, 4'h8, 2'h1}, '{2'h3, 3'h0, 3'h0, 4'hf, 2'h0}, '{2'h3, 3'h4, 3'h6, 4'hf, 2'h0},
        '{2'h3, 3'h7, 3'h7, 4'hf, 2'h0}, '{2'h2, 3'h1, 3'h1, 4'h8, 2'h2}, '{2'h1, 3'h1, 3'h1, 4'h8, 2'h0},
        '{2'h0, 3'h1, 3'h1, 4'h8, 2'h0}};
    logic        sys_clk = 1'b0;
    logic        srst = 1'b1;
    logic [11:0] reg_addr = 12'h0000;
    logic [7:0]  reg_wdata = 8'h00;
    logic        reg_wr = 1'b0;
    logic        reg_rd = 1'b0;
    logic [7:0]  reg_rdata;
    logic [1:0]  cs_count = 2'h3;
    sample_in_t  samp_in = '0;
    sample_out_t samp_out;
    logic [15:0] user_pattern_four;
    logic [15:0] rx_count_q;
    int          failures = 0;
    int          compares = 0;
    int          cycles = 0;

    always #50 sys_clk = ~sys_clk;

    control_bit_source_select #(.SAMPLE_W(12)) u_control_bit_source_select (
        .sys_clk(sys_clk), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cs_count(cs_count), .samp_in(samp_in),
        .samp_out(samp_out), .user_pattern_four(user_pattern_four));
    link_rx_model u_link_rx_model (.sys_clk(sys_clk), .srst(srst), .samp_out(samp_out), .rx_count_q(rx_count_q));

    task stop_test;
        if (failures == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : stop_test

    task chk(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("ERROR %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task wr(input logic [11:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    task rd(input logic [11:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1;
        chk({8'h00, reg_rdata}, {8'h00, exp});
    endtask : rd

    always @(posedge sys_clk) begin
        cycles++;
        if (cycles == 3000) begin
            failures++;
            stop_test();
        end
    end

    initial begin
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        rd(`CBS_OFF_SRC_CFG, `CBS_RST_SRC_CFG);
        rd(`CBS_OFF_PAT4_LO, `CBS_RST_PAT4_LO);
        rd(`CBS_OFF_PAT4_HI, `CBS_RST_PAT4_HI);
        // reset selectors give zero bits even with every source high
        @(posedge sys_clk);
        samp_in <= '{1'b0, 16'h1234, 4'hf};
        @(posedge sys_clk);
        #1;
        chk({14'h0000, samp_out.ctrl}, 16'h0000);
        for (int i = 0; i < NROWS; i++) begin
            wr(`CBS_OFF_SRC_CFG, {1'b0, rows[i].up, 1'b0, rows[i].lo});
            @(posedge sys_clk);
            cs_count <= rows[i].cs;
            samp_in <= '{1'b1, 16'hffff, rows[i].src};
            @(posedge sys_clk);
            samp_in.valid <= 1'b0;
            #1;
            chk({14'h0000, samp_out.ctrl}, {14'h0000, rows[i].exp});
            chk(samp_out.data, 16'h0fff);
        end
        wr(`CBS_OFF_SRC_CFG, 8'hff);
        rd(`CBS_OFF_SRC_CFG, 8'h77);
        wr(`CBS_OFF_PAT4_LO, 8'ha5);
        wr(`CBS_OFF_PAT4_HI, 8'h3c);
        rd(`CBS_OFF_PAT4_HI, 8'h3c);
        chk(user_pattern_four, 16'h3ca5);
        rd(12'h055a, `CBS_RD_UNMAPPED);
        chk(rx_count_q, 16'h000d);
        // mid-run reset clears selectors and pattern
        @(posedge sys_clk);
        srst <= 1'b1;
        cs_count <= 2'h3;
        samp_in <= '{1'b1, 16'hffff, 4'hf};
        repeat (2) @(posedge sys_clk);
        srst <= 1'b0;
        #1;
        chk(user_pattern_four, 16'h0000);
        rd(`CBS_OFF_SRC_CFG, `CBS_RST_SRC_CFG);
        chk({14'h0000, samp_out.ctrl}, 16'h0000);
        stop_test();
    end
endmodule : control_bit_source_select_tb_top
